// ### logic/ofd_top.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "ofd_cfg.svh"
module ofd_top import ofd_pkg::*; (
	input wire logic core_clk_i, // core clock, 25 MHz
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic [3:0] reg_addr_i, // register index
	input wire logic [31:0] reg_wdata_i, // register write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	output logic [31:0] reg_rdata_o, // read data, cycle after strobe
	input wire logic [15:0] instr_i, // fetched word, taken at last phase
	input wire logic [20:0] pc_i, // byte address of the fetched word
	input wire logic [11:0] ind_ptr_i, // indirect pointer for indexed forms
	input wire logic flush_i, // skip taken or pc changed
	input wire logic result_valid_i, // datapath result strobe
	input wire logic [7:0] result_i, // datapath result byte
	input wire logic [4:0] flag_upd_i, // per-flag update enables
	input wire logic [4:0] flag_val_i, // per-flag new values
	input wire logic tbl_rd_valid_i, // table read data strobe
	input wire logic [7:0] tbl_rd_data_i, // table read data
	output logic [1:0] phase_o, // phase within instruction cycle
	output logic issue_o, // fields below valid, one clock
	output ofd_fmt_t fmt_o, // instruction format
	output logic dest_file_o, // result to file register
	output logic [11:0] file_addr_o, // data memory address
	output logic [7:0] bit_onehot_o, // selected bit
	output logic [11:0] src_addr_o, // move source address
	output logic [11:0] dst_addr_o, // move destination address
	output logic [19:0] literal_o, // literal value
	output ofd_litw_t lit_width_o, // literal width
	output logic [1:0] ptr_sel_o, // indirect pointer designator
	output logic [20:0] target_o, // branch or jump target
	output logic fast_o, // fast call or return
	output logic table_req_o, // table access request, one clock
	output logic table_write_o, // table access is a write
	output logic [20:0] table_addr_o, // program memory address for table access
	output logic [7:0] table_latch_o, // table latch
	output logic [7:0] working_reg_o, // working register
	output logic [3:0] bank_select_o, // bank select register
	output logic [4:0] flags_o // carry, digit carry, zero, overflow, negative
);
	// ----------------------------------------------------------------------
	// field extractor on the word pair being issued
	// ----------------------------------------------------------------------
	ofd_fields_if fi ();
	ofd_field_xtract u_xtract (
		.fi(fi)
	);

	ofd_state_t state_r;
	ofd_state_t state_nxt;
	logic [1:0] phase_r;
	logic [15:0] hold_r;
	logic [15:0] ir_r;
	logic flush_pend_r;
	logic [3:0] bank_select_r;
	logic [3:0] bank_select_nxt;
	logic [7:0] working_reg_r;
	logic [7:0] working_reg_nxt;
	logic [4:0] flags_r;
	logic [4:0] flags_nxt;
	logic [20:0] table_pointer_r;
	logic [20:0] table_pointer_nxt;
	logic [7:0] table_latch_r;
	logic [7:0] table_latch_nxt;
	ofd_shadow_t shadow_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic issue_r;
	ofd_fmt_t fmt_r;
	logic dest_file_r;
	logic [11:0] file_addr_r;
	logic [7:0] bit_onehot_r;
	logic [11:0] src_addr_r;
	logic [11:0] dst_addr_r;
	logic [19:0] literal_r;
	ofd_litw_t lit_width_r;
	logic [1:0] ptr_sel_r;
	logic [20:0] target_r;
	logic fast_r;
	logic table_req_r;
	logic table_write_r;
	logic [20:0] table_addr_r;

	// ----------------------------------------------------------------------
	// instruction cycle sequencing
	// ----------------------------------------------------------------------
	// second word joins the held first word; a lone second word decodes as nop
	assign fi.word1 = (state_r == OFD_ST_SECOND) ? hold_r : instr_i;
	assign fi.word2 = (state_r == OFD_ST_SECOND) ? instr_i : `OFD_RST_WORD;
	assign fi.bank_select_register = bank_select_r;
	assign fi.ptr = ind_ptr_i;
	assign fi.pc = (state_r == OFD_ST_SECOND) ? pc_i - `OFD_PC_STEP : pc_i;

	wire last_phase = phase_r == `OFD_LAST_PHASE;
	wire in_second = state_r == OFD_ST_SECOND;
	// a pending bubble swallows the next word, unless that word is the second word of a pair
	wire bubble = last_phase & ~in_second & flush_pend_r;
	wire start_pair = last_phase & ~in_second & ~flush_pend_r & fi.two_word;
	wire do_issue = last_phase & ~bubble & ~start_pair;
	// a no-op issue, lone second words included, leaves the operand fields alone
	wire do_load = do_issue & (fi.fmt != OFD_FMT_NOP);
	wire issue_tbl = do_issue & (fi.fmt == OFD_FMT_TABLE);
	wire issue_movlb = do_issue & (fi.fmt == OFD_FMT_LIT)
		& (fi.word1[`OFD_F_HI8] == `OFD_HI8_MOVLB);
	wire save_shadow = do_issue & fi.fast & (fi.fmt == OFD_FMT_JUMP);
	wire load_shadow = do_issue & fi.fast & (fi.fmt == OFD_FMT_RETURN);

	// next state: pairs take two cycles, the first one issuing a nop
	always_comb begin
		state_nxt = state_r;
		if (last_phase) begin
			case (state_r)
				OFD_ST_FIRST: begin
					if (start_pair) begin
						state_nxt = OFD_ST_SECOND;
					end
				end
				OFD_ST_SECOND: begin
					state_nxt = OFD_ST_FIRST;
				end
				default: begin
					state_nxt = OFD_ST_FIRST;
				end
			endcase
		end
	end

	// phase counter wraps every four clocks
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			phase_r <= `OFD_RST_PHASE;
			state_r <= OFD_ST_FIRST;
		end else begin
			phase_r <= phase_r + 2'(1);
			state_r <= state_nxt;
		end
	end

	// a new flush wins over the bubble that consumes the old one
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			flush_pend_r <= 1'b0;
		end else begin
			flush_pend_r <= flush_i | (flush_pend_r & ~bubble);
		end
	end

	// first word of a pair is parked until its partner arrives
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			hold_r <= `OFD_RST_WORD;
			ir_r <= `OFD_RST_WORD;
		end else begin
			hold_r <= start_pair ? instr_i : hold_r;
			ir_r <= last_phase ? fi.word1 : ir_r;
		end
	end

	// ----------------------------------------------------------------------
	// registered operand fields, loaded at the issue edge
	// ----------------------------------------------------------------------
	// bubbles and pair starts issue a plain nop so the datapath never stalls
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			issue_r <= 1'b0;
			fmt_r <= OFD_FMT_NOP;
		end else begin
			issue_r <= last_phase;
			fmt_r <= last_phase ? (do_issue ? fi.fmt : OFD_FMT_NOP) : fmt_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dest_file_r <= 1'b0;
			file_addr_r <= 12'h000;
			bit_onehot_r <= `OFD_RST_BYTE;
			src_addr_r <= 12'h000;
			dst_addr_r <= 12'h000;
			literal_r <= 20'h0_0000;
			lit_width_r <= OFD_LW_NONE;
			ptr_sel_r <= 2'h0;
			target_r <= 21'h0_0000;
			fast_r <= 1'b0;
		end else if (do_load) begin
			dest_file_r <= fi.dest_file;
			file_addr_r <= fi.file_addr;
			bit_onehot_r <= fi.bit_onehot;
			src_addr_r <= fi.src_addr;
			dst_addr_r <= fi.dst_addr;
			literal_r <= fi.literal;
			lit_width_r <= fi.lit_width;
			ptr_sel_r <= fi.ptr_sel;
			target_r <= fi.target;
			fast_r <= fi.fast;
		end
	end

	// ----------------------------------------------------------------------
	// table pointer and latch
	// ----------------------------------------------------------------------
	// pre-increment moves before the access, post modes after it
	wire [20:0] tp_inc = table_pointer_r + `OFD_TP_STEP;
	wire [20:0] tp_dec = table_pointer_r - `OFD_TP_STEP;
	wire tm_inc = (fi.tbl_mode == `OFD_TM_POSTINC) | (fi.tbl_mode == `OFD_TM_PREINC);
	wire tm_dec = fi.tbl_mode == `OFD_TM_POSTDEC;
	wire [20:0] tp_access = (fi.tbl_mode == `OFD_TM_PREINC) ? tp_inc : table_pointer_r;

	// register bus decode
	wire wr_bsr = reg_wr_i & (reg_addr_i == `OFD_RA_BSR);
	wire wr_working_register = reg_wr_i & (reg_addr_i == `OFD_RA_WORKING_REGISTER);
	wire wr_flags = reg_wr_i & (reg_addr_i == `OFD_RA_FLAGS);
	wire wr_table_pointer = reg_wr_i & (reg_addr_i == `OFD_RA_TABLE_POINTER);
	wire wr_tbllat = reg_wr_i & (reg_addr_i == `OFD_RA_TBLLAT);

	// core activity wins over a software write in the same clock
	always_comb begin
		table_pointer_nxt = table_pointer_r;
		if (issue_tbl & tm_inc) begin
			table_pointer_nxt = tp_inc;
		end else if (issue_tbl & tm_dec) begin
			table_pointer_nxt = tp_dec;
		end else if (wr_table_pointer) begin
			table_pointer_nxt = reg_wdata_i[20:0];
		end
		table_latch_nxt = table_latch_r;
		if (tbl_rd_valid_i) begin
			table_latch_nxt = tbl_rd_data_i;
		end else if (wr_tbllat) begin
			table_latch_nxt = reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			table_pointer_r <= `OFD_RST_TABLE_POINTER;
			table_latch_r <= `OFD_RST_BYTE;
			table_req_r <= 1'b0;
			table_write_r <= 1'b0;
			table_addr_r <= `OFD_RST_TABLE_POINTER;
		end else begin
			table_pointer_r <= table_pointer_nxt;
			table_latch_r <= table_latch_nxt;
			table_req_r <= issue_tbl;
			table_write_r <= issue_tbl ? fi.tbl_write : table_write_r;
			table_addr_r <= issue_tbl ? tp_access : table_addr_r;
		end
	end

	// ----------------------------------------------------------------------
	// bank select, working register, flags, shadows
	// ----------------------------------------------------------------------
	// fast return restores; otherwise core writes beat software writes
	always_comb begin
		bank_select_nxt = bank_select_r;
		if (load_shadow) begin
			bank_select_nxt = shadow_r.bank_select_register;
		end else if (issue_movlb) begin
			bank_select_nxt = fi.word1[`OFD_F_K4];
		end else if (wr_bsr) begin
			bank_select_nxt = reg_wdata_i[3:0];
		end
		working_reg_nxt = working_reg_r;
		if (load_shadow) begin
			working_reg_nxt = shadow_r.working_register;
		end else if (result_valid_i & ~dest_file_r) begin
			working_reg_nxt = result_i;
		end else if (wr_working_register) begin
			working_reg_nxt = reg_wdata_i[7:0];
		end
	end

	// each flag follows the datapath only where its enable is set
	for (genvar i = 0; i < 5; i++) begin : g_flag
		assign flags_nxt[i] = load_shadow ? shadow_r.flags[i]
			: flag_upd_i[i] ? flag_val_i[i]
			: wr_flags ? reg_wdata_i[i] : flags_r[i];
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bank_select_r <= `OFD_RST_BSR;
			working_reg_r <= `OFD_RST_BYTE;
			flags_r <= `OFD_RST_FLAGS;
		end else begin
			bank_select_r <= bank_select_nxt;
			working_reg_r <= working_reg_nxt;
			flags_r <= flags_nxt;
		end
	end

	// shadows change only on a fast call, never otherwise
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			shadow_r <= '{bank_select_register: `OFD_RST_BSR, flags: `OFD_RST_FLAGS, working_register: `OFD_RST_BYTE};
		end else if (save_shadow) begin
			shadow_r <= '{bank_select_register: bank_select_r, flags: flags_r, working_register: working_reg_r};
		end
	end

	// ----------------------------------------------------------------------
	// register read port, data stands one cycle after the strobe
	// ----------------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`OFD_RA_BSR: rdata_nxt = 32'(bank_select_r);
				`OFD_RA_WORKING_REGISTER: rdata_nxt = 32'(working_reg_r);
				`OFD_RA_FLAGS: rdata_nxt = 32'(flags_r);
				`OFD_RA_TABLE_POINTER: rdata_nxt = 32'(table_pointer_r);
				`OFD_RA_TBLLAT: rdata_nxt = 32'(table_latch_r);
				`OFD_RA_SHADOW: rdata_nxt = 32'(shadow_r);
				`OFD_RA_IR: rdata_nxt = 32'(ir_r);
				`OFD_RA_FADDR: rdata_nxt = 32'(file_addr_r);
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign reg_rdata_o = rdata_r;
	assign phase_o = phase_r;
	assign issue_o = issue_r;
	assign fmt_o = fmt_r;
	assign dest_file_o = dest_file_r;
	assign file_addr_o = file_addr_r;
	assign bit_onehot_o = bit_onehot_r;
	assign src_addr_o = src_addr_r;
	assign dst_addr_o = dst_addr_r;
	assign literal_o = literal_r;
	assign lit_width_o = lit_width_r;
	assign ptr_sel_o = ptr_sel_r;
	assign target_o = target_r;
	assign fast_o = fast_r;
	assign table_req_o = table_req_r;
	assign table_write_o = table_write_r;
	assign table_addr_o = table_addr_r;
	assign table_latch_o = table_latch_r;
	assign working_reg_o = working_reg_r;
	assign bank_select_o = bank_select_r;
	assign flags_o = flags_r;
endmodule

// ### logic/ofd_cfg.svh
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH
// ----------------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------------
`define OFD_F_OPC 15:12
`define OFD_F_SUB 11:8
`define OFD_F_HI8 15:8
`define OFD_F_LO8 7:0
`define OFD_F_D 9
`define OFD_F_A 8
`define OFD_F_LIT8 11
`define OFD_F_BIT 11:9
`define OFD_F_ADDR12 11:0
`define OFD_F_BRA 10:0
`define OFD_F_PTR 5:4
`define OFD_F_LFSRZ 7:6
`define OFD_F_K4 3:0
`define OFD_F_Z 6:0
`define OFD_F_MOVSS 7
`define OFD_F_CALL_S 8
`define OFD_F_RET_S 0
`define OFD_F_TBLHI 7:3
`define OFD_F_TBL_W 2
`define OFD_F_TBL_M 1:0
`define OFD_F_RETHI 7:2
// ----------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------
`define OFD_OP_ZERO 4'h0
`define OFD_OP_BTG 4'h7
`define OFD_OP_BITHI 2'h2
`define OFD_OP_MOVFF 4'hc
`define OFD_OP_BRA 4'hd
`define OFD_OP_CTL 4'he
`define OFD_OP_CONT 4'hf
`define OFD_SUB_CALL 3'h6
`define OFD_SUB_MOVSX 4'hb
`define OFD_SUB_LFSR 4'he
`define OFD_SUB_GOTO 4'hf
`define OFD_HI8_MISC 8'h00
`define OFD_HI8_MOVLB 8'h01
`define OFD_TBL_HI 5'h01
`define OFD_RET_HI 6'h04
`define OFD_LFSR_Z 2'h0
`define OFD_TM_NONE 2'h0
`define OFD_TM_POSTINC 2'h1
`define OFD_TM_POSTDEC 2'h2
`define OFD_TM_PREINC 2'h3
// ----------------------------------------------------------------------
// access RAM, timing, register map, reset values
// ----------------------------------------------------------------------
`define OFD_ACC_SPLIT 8'h60
`define OFD_ACC_LO_BANK 4'h0
`define OFD_ACC_HI_BANK 4'hf
`define OFD_LAST_PHASE 2'h3
`define OFD_PC_STEP 21'h0_0002
`define OFD_TP_STEP 21'h0_0001
`define OFD_RA_BSR 4'h0
`define OFD_RA_WORKING_REGISTER 4'h1
`define OFD_RA_FLAGS 4'h2
`define OFD_RA_TABLE_POINTER 4'h3
`define OFD_RA_TBLLAT 4'h4
`define OFD_RA_SHADOW 4'h5
`define OFD_RA_IR 4'h6
`define OFD_RA_FADDR 4'h7
`define OFD_RST_BSR 4'h0
`define OFD_RST_BYTE 8'h00
`define OFD_RST_FLAGS 5'h00
`define OFD_RST_TABLE_POINTER 21'h0_0000
`define OFD_RST_WORD 16'h0000
`define OFD_RST_PHASE 2'h0
`endif

// ### logic/ofd_pkg.sv
package ofd_pkg;
	typedef enum logic [3:0] {
		OFD_FMT_NOP, OFD_FMT_BYTE, OFD_FMT_BIT, OFD_FMT_MOVFF, OFD_FMT_LIT,
		OFD_FMT_BRANCH, OFD_FMT_JUMP, OFD_FMT_TABLE, OFD_FMT_RETURN,
		OFD_FMT_LFSR, OFD_FMT_INDEXED, OFD_FMT_MISC
	} ofd_fmt_t;
	typedef enum logic [1:0] {OFD_LW_NONE, OFD_LW_8, OFD_LW_12, OFD_LW_20} ofd_litw_t;
	typedef enum {OFD_ST_FIRST, OFD_ST_SECOND} ofd_state_t;
	typedef struct packed {
		logic [3:0] bank_select_register;
		logic [4:0] flags;
		logic [7:0] working_register;
	} ofd_shadow_t;
endpackage

// ### logic/ofd_fields_if.sv
`timescale 1ns/100ps
interface ofd_fields_if;
	import ofd_pkg::*;
	logic [15:0] word1;
	logic [15:0] word2;
	logic [3:0] bank_select_register;
	logic [11:0] ptr;
	logic [20:0] pc;
	ofd_fmt_t fmt;
	logic two_word;
	logic dest_file;
	logic [11:0] file_addr;
	logic [7:0] bit_onehot;
	logic [11:0] src_addr;
	logic [11:0] dst_addr;
	logic [19:0] literal;
	ofd_litw_t lit_width;
	logic [1:0] ptr_sel;
	logic [1:0] tbl_mode;
	logic tbl_write;
	logic [20:0] target;
	logic fast;
	modport xtract (input word1, word2, bank_select_register, ptr, pc, output fmt, two_word, dest_file,
		file_addr, bit_onehot, src_addr, dst_addr, literal, lit_width, ptr_sel,
		tbl_mode, tbl_write, target, fast);
	modport core (output word1, word2, bank_select_register, ptr, pc, input fmt, two_word, dest_file,
		file_addr, bit_onehot, src_addr, dst_addr, literal, lit_width, ptr_sel,
		tbl_mode, tbl_write, target, fast);
endinterface

// ### logic/ofd_field_xtract.sv
`timescale 1ns/100ps
`include "ofd_cfg.svh"
module ofd_field_xtract import ofd_pkg::*; (
	ofd_fields_if.xtract fi // word pair in, operand fields out
);
	// ----------------------------------------------------------------------
	// opcode classes; don't-care bits are never compared
	// ----------------------------------------------------------------------
	wire [3:0] opc = fi.word1[`OFD_F_OPC];
	wire [3:0] sub = fi.word1[`OFD_F_SUB];
	wire [7:0] f8 = fi.word1[`OFD_F_LO8];
	wire is_ctl = opc == `OFD_OP_CTL;
	wire is_zero = opc == `OFD_OP_ZERO;
	wire is_movff = opc == `OFD_OP_MOVFF;
	wire is_cont = opc == `OFD_OP_CONT;
	wire is_bit = (opc == `OFD_OP_BTG) | (opc[3:2] == `OFD_OP_BITHI);
	wire is_bra = opc == `OFD_OP_BRA;
	wire is_bcond = is_ctl & ~sub[3];
	wire is_call = is_ctl & (sub[3:1] == `OFD_SUB_CALL);
	wire is_goto = is_ctl & (sub == `OFD_SUB_GOTO);
	wire is_lfsr = is_ctl & (sub == `OFD_SUB_LFSR) & (fi.word1[`OFD_F_LFSRZ] == `OFD_LFSR_Z);
	wire is_movsx = is_ctl & (sub == `OFD_SUB_MOVSX);
	wire is_misc0 = fi.word1[`OFD_F_HI8] == `OFD_HI8_MISC;
	wire is_tbl = is_misc0 & (fi.word1[`OFD_F_TBLHI] == `OFD_TBL_HI);
	wire is_ret = is_misc0 & (fi.word1[`OFD_F_RETHI] == `OFD_RET_HI);
	wire is_movlb = fi.word1[`OFD_F_HI8] == `OFD_HI8_MOVLB;
	wire is_lit = is_zero & (fi.word1[`OFD_F_LIT8] | is_movlb);
	wire is_byte = (~is_zero | ~is_misc0) & ~is_lit & ~is_ctl & ~is_bit & ~is_bra
		& ~is_movff & ~is_cont;
	// ----------------------------------------------------------------------
	// format and operand fields
	// ----------------------------------------------------------------------
	assign fi.fmt = is_cont ? OFD_FMT_NOP : is_byte ? OFD_FMT_BYTE : is_bit ? OFD_FMT_BIT
		: is_movff ? OFD_FMT_MOVFF : is_lit ? OFD_FMT_LIT : (is_bra | is_bcond) ? OFD_FMT_BRANCH
		: (is_call | is_goto) ? OFD_FMT_JUMP : is_tbl ? OFD_FMT_TABLE : is_ret ? OFD_FMT_RETURN
		: is_lfsr ? OFD_FMT_LFSR : is_movsx ? OFD_FMT_INDEXED : is_zero ? OFD_FMT_NOP
		: OFD_FMT_MISC;
	assign fi.two_word = is_movff | is_call | is_goto | is_lfsr | is_movsx;
	assign fi.dest_file = is_bit | (is_byte & fi.word1[`OFD_F_D]);
	// banked or access RAM; the split point is a build constant
	wire [3:0] acc_bank = (f8 < `OFD_ACC_SPLIT) ? `OFD_ACC_LO_BANK : `OFD_ACC_HI_BANK;
	wire [11:0] movff_src = fi.word1[`OFD_F_ADDR12];
	wire [11:0] idx_src = fi.ptr + 12'(fi.word1[`OFD_F_Z]);
	wire [11:0] idx_dst = fi.ptr + 12'(fi.word2[`OFD_F_Z]);
	assign fi.file_addr = is_movff ? movff_src : is_movsx ? idx_src
		: {fi.word1[`OFD_F_A] ? fi.bank_select_register : acc_bank, f8};
	assign fi.src_addr = is_movff ? movff_src : idx_src;
	// the indexed-destination form is told apart by the first word, not the second
	assign fi.dst_addr = (is_movsx & fi.word1[`OFD_F_MOVSS]) ? idx_dst
		: fi.word2[`OFD_F_ADDR12];
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign fi.bit_onehot[i] = is_bit & (fi.word1[`OFD_F_BIT] == 3'(i));
	end
	// literal widths: 8 plain, 12 for pointer loads, 20 for jumps
	wire [19:0] lit12 = 20'({fi.word1[`OFD_F_K4], fi.word2[`OFD_F_LO8]});
	wire [19:0] lit20 = {fi.word2[`OFD_F_ADDR12], f8};
	assign fi.literal = is_lfsr ? lit12 : (is_call | is_goto) ? lit20 : 20'(f8);
	assign fi.lit_width = is_lfsr ? OFD_LW_12 : (is_call | is_goto) ? OFD_LW_20
		: is_lit ? OFD_LW_8 : OFD_LW_NONE;
	assign fi.ptr_sel = fi.word1[`OFD_F_PTR];
	assign fi.tbl_mode = fi.word1[`OFD_F_TBL_M];
	assign fi.tbl_write = fi.word1[`OFD_F_TBL_W];
	// relative offsets are words, hence the doubling into byte addresses
	wire [20:0] rel_off = is_bra ? 21'(signed'(fi.word1[`OFD_F_BRA])) : 21'(signed'(f8));
	wire [20:0] rel_tgt = fi.pc + `OFD_PC_STEP + {rel_off[19:0], 1'b0};
	assign fi.target = (is_call | is_goto) ? {lit20, 1'b0} : rel_tgt;
	assign fi.fast = is_call ? fi.word1[`OFD_F_CALL_S]
		: is_ret & fi.word1[`OFD_F_RET_S];
endmodule

// ### tb/ofd_chk_sva.sv
`timescale 1ns/100ps
module ofd_chk import ofd_pkg::*; (
	input wire logic core_clk_i, // core clock
	input wire logic sys_rst_i, // sync reset
	input wire logic [3:0] reg_addr_i, // register index
	input wire logic reg_rd_i, // read strobe
	input wire logic [31:0] reg_rdata_o, // read data
	input wire logic [1:0] phase_o, // phase
	input wire logic issue_o, // issue pulse
	input wire ofd_fmt_t fmt_o, // format
	input wire logic [11:0] file_addr_o, // data address
	input wire logic [7:0] bit_onehot_o, // selected bit
	input wire logic [19:0] literal_o, // literal
	input wire ofd_litw_t lit_width_o, // literal width
	input wire logic [20:0] target_o, // target
	input wire logic table_req_o, // table request
	input wire logic [3:0] bank_select_o // bank select
);
	// ----------------------------------------
	// decoder timing and field checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// a word is taken at phase 3 and issued one clock later
	sequence s_take;
		phase_o == 2'h3 ##1 issue_o;
	endsequence
	phase_wrap_a: assert property (phase_o == 2'h3 |=> issue_o && phase_o == 2'h0)
		else $error("no issue after phase 3");
	issue_space_a: assert property (s_take |-> ##1 !issue_o [*3])
		else $error("issue closer than four clocks");
	bit_select_a: assert property (issue_o && fmt_o == OFD_FMT_BIT |-> $onehot(bit_onehot_o))
		else $error("bit select not one-hot");
	jump_width_a: assert property (issue_o && fmt_o == OFD_FMT_JUMP |->
		lit_width_o == OFD_LW_20) else $error("jump literal width wrong");
	jump_target_a: assert property (issue_o && fmt_o == OFD_FMT_JUMP |->
		target_o == {literal_o, 1'b0}) else $error("jump target not absolute");
	bank_read_a: assert property (reg_rd_i && reg_addr_i == 4'h0 |=>
		reg_rdata_o == {28'h000_0000, $past(bank_select_o)}) else $error("bank read wrong");
	table_issue_a: assert property (table_req_o |-> issue_o)
		else $error("table request off issue");
	nop_hold_a: assert property (issue_o && fmt_o == OFD_FMT_NOP |-> $stable(file_addr_o))
		else $error("fields moved on no-op");
endmodule

// ### tb/ofd_top_tb.sv
`timescale 1ns/100ps
module ofd_top_tb import ofd_pkg::*;;
	logic core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, flush_i = 1'b0;
	logic result_valid_i = 1'b0, tbl_rd_valid_i = 1'b0, issue_o, dest_file_o, fast_o;
	logic table_req_o, table_write_o;
	logic [3:0] reg_addr_i = 4'h0, bank_select_o;
	logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
	logic [15:0] instr_i = 16'h0000;
	logic [20:0] pc_i = 21'h00_0000, target_o, table_addr_o;
	logic [11:0] ind_ptr_i = 12'h100, file_addr_o, src_addr_o, dst_addr_o;
	logic [7:0] result_i = 8'h00, tbl_rd_data_i = 8'h00, bit_onehot_o, table_latch_o, working_reg_o;
	logic [4:0] flag_upd_i = 5'h00, flag_val_i = 5'h00, flags_o;
	logic [1:0] phase_o, ptr_sel_o;
	logic [19:0] literal_o;
	ofd_fmt_t fmt_o;
	ofd_litw_t lit_width_o;
	int fails = 0, n_compared = 0;
	ofd_top u_ofd_top (.*);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rw(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rr(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask
	// waits for phase 2 so the word is present across the phase-3 sampling edge
	task automatic iss(input logic [15:0] w, input logic [20:0] p = 21'h00_0000,
		input logic fl = 1'b0);
		int i;
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk_i);
			#1;
			if (phase_o === 2'h2) break;
		end
		if (i == 8) begin
			fails++;
			complete_run();
		end
		@(posedge core_clk_i);
		instr_i <= w;
		pc_i <= p;
		flush_i <= fl;
		@(posedge core_clk_i);
		flush_i <= 1'b0;
		instr_i <= 16'h0000; // idle word, so a late caller never re-issues a stale one
		#1;
		chk(32'(issue_o), 32'h0000_0001);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rw(4'h0, 32'h0000_0005);
		rr(4'h0, 32'h0000_0005);
		rw(4'h9, 32'h0000_00ff);
		rr(4'h9, 32'h0000_0000);
		@(posedge core_clk_i);
		flag_upd_i <= 5'h1f;
		flag_val_i <= 5'h15;
		tbl_rd_valid_i <= 1'b1;
		tbl_rd_data_i <= 8'ha5;
		result_valid_i <= 1'b1;
		result_i <= 8'h3c;
		@(posedge core_clk_i);
		flag_upd_i <= 5'h00;
		tbl_rd_valid_i <= 1'b0;
		result_valid_i <= 1'b0;
		#1;
		chk(32'(flags_o), 32'h0000_0015);
		chk(32'(working_reg_o), 32'h0000_003c);
		chk(32'(table_latch_o), 32'h0000_00a5);
		$display("t_regs done");
	endtask
	// low, high access halves and banked form, bank select holds 5
	task automatic t_byte;
		logic [15:0] w[3] = '{16'h2654, 16'h24a0, 16'h2534};
		logic [11:0] fa[3] = '{12'h054, 12'hfa0, 12'h534};
		for (int k = 0; k < 3; k++) begin
			iss(w[k]);
			chk(32'(fmt_o), 32'(OFD_FMT_BYTE));
			chk(32'(file_addr_o), 32'(fa[k]));
			chk(32'(dest_file_o), 32'(k == 0));
		end
		for (int b = 0; b < 8; b++) begin
			iss({4'h8, 3'(b), 9'h012});
			chk(32'(bit_onehot_o), 32'h0000_0001 << b);
			chk(32'(file_addr_o), 32'h0000_0012);
		end
		$display("t_byte done");
	endtask
	// a flush beside one word turns the next word into a bubble with fields held
	task automatic t_flush;
		iss(16'h2654, 21'h00_0000, 1'b1);
		iss(16'h2534);
		chk(32'(fmt_o), 32'(OFD_FMT_NOP));
		chk(32'(file_addr_o), 32'h0000_0054);
		iss(16'h2534);
		chk(32'(file_addr_o), 32'h0000_0534);
		$display("t_flush done");
	endtask
	// pair at the address extremes, then a lone second word
	task automatic t_pair;
		iss(16'hcfff);
		chk(32'(fmt_o), 32'(OFD_FMT_NOP));
		iss(16'hf000);
		chk(32'(fmt_o), 32'(OFD_FMT_MOVFF));
		chk(32'(src_addr_o), 32'h0000_0fff);
		chk(32'(dst_addr_o), 32'h0000_0000);
		iss(16'hf123);
		chk(32'(fmt_o), 32'(OFD_FMT_NOP));
		chk(32'(dst_addr_o), 32'h0000_0000);
		chk(32'(file_addr_o), 32'h0000_0fff);
		iss(16'hee12);
		iss(16'hf034);
		chk(32'(literal_o), 32'h0000_0234);
		chk(32'(lit_width_o), 32'(OFD_LW_12));
		chk(32'(ptr_sel_o), 32'h0000_0001);
		iss(16'heb83);
		iss(16'hf005);
		chk(32'(src_addr_o), 32'h0000_0103);
		chk(32'(dst_addr_o), 32'h0000_0105);
		$display("t_pair done");
	endtask
	task automatic t_jump;
		iss(16'hd7ff, 21'h00_0100);
		chk(32'(target_o), 32'h0000_0100);
		iss(16'hef34, 21'h00_0200);
		iss(16'hf012, 21'h00_0202);
		chk(32'(literal_o), 32'h0000_1234);
		chk(32'(lit_width_o), 32'(OFD_LW_20));
		chk(32'(target_o), 32'h0000_2468);
		chk(32'(fast_o), 32'h0000_0000);
		iss(16'hed00);
		iss(16'hf000);
		chk(32'(fast_o), 32'h0000_0001);
		rr(4'h5, 32'h0000_b53c);
		rw(4'h0, 32'h0000_0009);
		iss(16'h0013);
		chk(32'(bank_select_o), 32'h0000_0005);
		$display("t_jump done");
	endtask
	// all four pointer modes across the bit-20 carry
	task automatic t_table;
		logic [20:0] p = 21'h0f_ffff;
		rw(4'h3, 32'(p));
		for (int m = 0; m < 4; m++) begin
			iss({13'h0001, 1'(m), 2'(m)});
			chk(32'(table_req_o), 32'h0000_0001);
			chk(32'(table_write_o), 32'(m % 2));
			chk(32'(table_addr_o), 32'((m == 3) ? p + 21'h00_0001 : p));
			p = (m == 1 || m == 3) ? p + 21'h00_0001 : (m == 2) ? p - 21'h00_0001 : p;
			rr(4'h3, 32'(p));
		end
		$display("t_table done");
	endtask
	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_byte();
		t_flush();
		t_pair();
		t_jump();
		t_table();
		complete_run();
	end
endmodule
bind ofd_top ofd_chk u_ofd_chk (.*);
